// File: logic/data_memory.sv
`timescale 1ns/10ps
module data_memory
  import data_memory_pkg::*;
#(
  parameter logic [1:0] VARIANT = VARIANT_LARGE
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Core data access
  input  wire logic [7:0]  addr_i,
  input  wire logic        rd_en_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic        wr_en_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        bit_en_i,
  input  wire logic [2:0]  bit_sel_i,
  input  wire logic        bit_val_i,
  // Table read request
  input  wire logic        tab_rd_i,
  input  wire logic        tab_last_i,
  input  wire logic [7:0]  tab_dest_i,
  input  wire logic [11:0] pc_i,
  output logic             busy_o,
  // Program memory fetch
  output logic             prog_req_o,
  output logic      [11:0] prog_addr_o,
  input  wire logic        prog_valid_i,
  input  wire logic [15:0] prog_data_i,
  // System flags and program counter load
  input  wire logic        status_to_i,
  input  wire logic        status_pdf_i,
  output logic             pcl_wr_o,
  output logic      [7:0]  pcl_data_o
);

  // ==========================================================
  // Storage
  // One flat array; unused entries are
  // ignored by writes and read as zero
  logic [7:0] mem [0:255];
  tab_state_t state;
  logic [7:0] tab_dest;
  logic [7:0] eff_addr;
  logic [7:0] cur_val;
  logic [7:0] tab_eff;

  // ==========================================================
  // Address map seen by the core
  // 00H window 0, follows pointer 0
  // 01H pointer 0
  // 02H window 1, follows pointer 1
  // 03H pointer 1
  // 04H unused
  // 05H accumulator
  // 06H program counter low, from pc_i
  // 07H table pointer
  // 08H table high byte, read-only
  // 09H watchdog setup
  // 0AH status, bits 4 and 5 live
  // 0BH interrupt control 0
  // 0CH unused
  // 0DH timer 0 count
  // 0EH timer 0 control
  // 0FH unused
  // 10H timer 1 count, larger parts
  // 11H timer 1 control, larger parts
  // 12H port A data
  // 13H port A direction
  // 14H port A pull-up
  // 15H port A wake-up
  // 16H control 0
  // 17H control 1
  // 18H result low, larger parts
  // 19H result high
  // 1AH converter control
  // 1BH converter clock setup
  // 1CH pulse width duty
  // 1DH unused
  // 1EH interrupt control 1, larger
  // 1FH unused
  // 20H general RAM to 5FH/7FH/BFH
  // Above the RAM end all reads zero
  // Unused bytes ignore writes too

  // ==========================================================
  // Variant constants
  // Small: 64 bytes, 10-bit table, 14-bit word
  // Medium: 96 bytes, 11-bit table, 14-bit word
  // Large: 160 bytes, 12-bit table, 15-bit word
  // Only the large part needs pointer bit 7
  localparam logic        LARGER    = (VARIANT != VARIANT_SMALL);
  localparam logic [7:0]  GPR_END   = (VARIANT == VARIANT_SMALL)  ? GPR_END_SMALL :
                                      (VARIANT == VARIANT_MEDIUM) ? GPR_END_MEDIUM :
                                                                    GPR_END_LARGE;
  localparam logic [11:0] PROG_MASK = (VARIANT == VARIANT_SMALL)  ? PROG_MASK_SMALL :
                                      (VARIANT == VARIANT_MEDIUM) ? PROG_MASK_MEDIUM :
                                                                    PROG_MASK_LARGE;
  localparam logic [7:0]  HIGH_MASK = (VARIANT == VARIANT_LARGE)  ? HIGH_MASK_15 :
                                                                    HIGH_MASK_14;

  // ==========================================================
  // Decode functions
  // Shared by core path, table path and
  // write enable, so all agree on the map
  // Resolution is one level deep: a pointer
  // aimed at a window lands on a window,
  // which has no storage, so reads give
  // zero and writes vanish

  // True where a real byte lives; windows hold none
  function automatic logic is_impl(input logic [7:0] a);
    logic sfr;
    sfr = (a == ADDR_MEMORY_POINTER_0)      || (a == ADDR_MEMORY_POINTER_1) ||
          (a == ADDR_ACCUMULATOR)           || (a == ADDR_PROGRAM_COUNTER_LOW) ||
          (a == ADDR_TABLE_POINTER)         || (a == ADDR_TABLE_HIGH_BYTE) ||
          (a == ADDR_WATCHDOG_SETUP)        || (a == ADDR_STATUS) ||
          (a == ADDR_INTERRUPT_CONTROL_0)   || (a == ADDR_TIMER0_COUNT) ||
          (a == ADDR_TIMER0_CONTROL)        || (a == ADDR_PORT_A_DATA) ||
          (a == ADDR_PORT_A_DIRECTION)      || (a == ADDR_PORT_A_PULLUP) ||
          (a == ADDR_PORT_A_WAKEUP)         || (a == ADDR_CONTROL_0) ||
          (a == ADDR_CONTROL_1)             || (a == ADDR_CONVERSION_RESULT_HIGH) ||
          (a == ADDR_CONVERTER_CONTROL)     || (a == ADDR_CONVERTER_CLOCK_SETUP) ||
          (a == ADDR_PULSE_WIDTH_DUTY);
    if (LARGER) begin
      sfr = sfr || (a == ADDR_TIMER1_COUNT) || (a == ADDR_TIMER1_CONTROL) ||
            (a == ADDR_CONVERSION_RESULT_LOW) || (a == ADDR_INTERRUPT_CONTROL_1);
    end
    // General area follows the special area directly
    return sfr || ((a >= GPR_START) && (a <= GPR_END));
  endfunction

  // Window addresses resolve through their pointer
  function automatic logic [7:0] resolve(input logic [7:0] a);
    if (a == ADDR_INDIRECT_WINDOW_0) begin
      return mem[ADDR_MEMORY_POINTER_0];
    end else if (a == ADDR_INDIRECT_WINDOW_1) begin
      return mem[ADDR_MEMORY_POINTER_1];
    end else begin
      return a;
    end
  endfunction

  // Value seen by a read at a resolved address
  function automatic logic [7:0] read_val(input logic [7:0] a);
    logic [7:0] v;
    v = ZERO_BYTE;
    if (!is_impl(a)) begin
      v = ZERO_BYTE;
    end else if (a == ADDR_PROGRAM_COUNTER_LOW) begin
      v = pc_i[7:0];
    end else if (a == ADDR_STATUS) begin
      v = mem[a];
      v[STATUS_TO_BIT]  = status_to_i;
      v[STATUS_PDF_BIT] = status_pdf_i;
    end else if ((a == ADDR_MEMORY_POINTER_0) || (a == ADDR_MEMORY_POINTER_1)) begin
      v = mem[a];
      if (VARIANT != VARIANT_LARGE) begin
        v[POINTER_TOP_BIT] = 1'b1;
      end
    end else begin
      v = mem[a];
    end
    return v;
  endfunction

  // Program writes may change this address
  function automatic logic is_writable(input logic [7:0] a);
    return is_impl(a) && (a != ADDR_TABLE_HIGH_BYTE);
  endfunction

  // ==========================================================
  // Core access decode
  // A process, not wires: it must follow
  // pointer and array changes at once
  always_comb begin
    eff_addr = resolve(addr_i);
    cur_val  = read_val(eff_addr);
    tab_eff  = resolve(tab_dest);
  end
  wire logic [7:0] bit_mask  = 8'h01 << bit_sel_i;
  // Bit ops are a read-modify-write of the visible value
  wire logic [7:0] bit_val   = bit_val_i ? (cur_val | bit_mask)
                                         : (cur_val & ~bit_mask);
  wire logic [7:0] core_data = bit_en_i ? bit_val : wr_data_i;
  wire logic       core_wr   = (wr_en_i || bit_en_i) && is_writable(eff_addr);
  wire logic       tab_done  = (state == TAB_FETCH) && prog_valid_i;

  // Table address: page bits from the PC or forced to ones
  wire logic [11:0] tab_addr = (tab_last_i ? {LAST_PAGE_BITS, mem[ADDR_TABLE_POINTER]}
                                           : {pc_i[11:8], mem[ADDR_TABLE_POINTER]})
                               & PROG_MASK;

  // Handshake outputs
  assign busy_o     = (state == TAB_FETCH);
  assign prog_req_o = (state == TAB_FETCH);

  // ==========================================================
  // Core interface timing
  // Read: enable at one edge, data the
  // next cycle, held until the next read
  // Write: one edge; a read in the same
  // cycle still sees the old value
  // Bit op: read-modify-write of the
  // visible byte in a single edge
  // Table read: taken only while idle;
  // busy rises next cycle, falls after
  // the edge that sees prog_valid_i
  // No upper bound on the fetch wait
  // Core writes while busy may be lost
  //
  // Last page, small part, pointer 06H:
  //   c0 tab_rd_i and tab_last_i high
  //   c1 busy, address 306H, word valid
  //   c2 idle, both bytes stored
  //
  // Hazards
  // A window destination is resolved
  // when the word lands, not on request
  // A destination on a window whose
  // pointer aims at a window, or on the
  // program counter low, drops the low
  // byte; the table high byte is kept
  // Program counter low has no storage;
  // a write leaves as a pcl_wr_o pulse

  // ==========================================================
  // Table read sequencer
  // Idle: waits for a request, latches
  // destination and the program address
  // Fetch: holds the request until the
  // word arrives; requests are ignored
  // Address is latched so a moving PC or
  // table pointer cannot disturb it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= TAB_IDLE;
      tab_dest    <= ZERO_BYTE;
      prog_addr_o <= 12'h000;
    end else begin
      case (state)
        TAB_IDLE: begin
          if (tab_rd_i) begin
            state       <= TAB_FETCH;
            tab_dest    <= tab_dest_i;
            prog_addr_o <= tab_addr;
          end
        end
        TAB_FETCH: begin
          if (prog_valid_i) begin
            state <= TAB_IDLE;
          end
        end
        default: begin
          state <= TAB_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Memory writes; the table result wins over a core write
  // because the core is told to wait while busy
  // Reset clears only the special area;
  // general RAM keeps its old contents,
  // so software must initialise it
  // Table high is masked to word width
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SFR_COUNT; i++) begin
        mem[i] <= SFR_RESET;
      end
    end else if (tab_done) begin
      // Window-to-window targets are dropped
      if (is_writable(tab_eff) && (tab_eff != ADDR_PROGRAM_COUNTER_LOW)) begin
        mem[tab_eff] <= prog_data_i[7:0];
      end
      mem[ADDR_TABLE_HIGH_BYTE] <= prog_data_i[15:8] & HIGH_MASK;
    end else if (core_wr && (eff_addr != ADDR_PROGRAM_COUNTER_LOW)) begin
      mem[eff_addr] <= core_data;
    end
  end

  // ==========================================================
  // Read data and program counter load
  // Data moves only on a taken read, so
  // the core may sample it at leisure;
  // live flags are captured at that edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o  <= ZERO_BYTE;
      pcl_wr_o   <= 1'b0;
      pcl_data_o <= ZERO_BYTE;
    end else begin
      if (rd_en_i) begin
        rd_data_o <= cur_val;
      end
      // PC low has no storage here; the sequencer takes the jump
      pcl_wr_o <= core_wr && !tab_done && (eff_addr == ADDR_PROGRAM_COUNTER_LOW);
      if (core_wr && (eff_addr == ADDR_PROGRAM_COUNTER_LOW)) begin
        pcl_data_o <= core_data;
      end
    end
  end

  // ==========================================================
  // Limits and trade-offs
  // Windows hold nothing; reading one
  // directly returns its target byte
  // Pointer bit 7 is stored on all parts
  // but forced to one when read on the
  // two smaller ones; bit ops on other
  // bits store it back as one
  // Status flags 4 and 5 always show the
  // inputs; writes to them are stored
  // but never seen
  // Table high accepts no program write
  // Conversion result bytes stay
  // writable so software can preload
  // Reset values of all special bytes
  // are zero; real peripherals may
  // override them outside this block
  // Only one table read is in flight;
  // the core must wait on busy_o
  // Bit ops and writes must not share
  // an edge; bit ops take priority
  // Reads never have side effects here
  // Decoding goes through the pointer
  // bytes, so timing is a compare, a pointer
  // read, a second compare and the array read

endmodule

// File: logic/data_memory_pkg.sv
package data_memory_pkg;

  // ==========================================================
  // Variant selection
  localparam logic [1:0] VARIANT_SMALL  = 2'h0;  // 1K program, 64 byte RAM
  localparam logic [1:0] VARIANT_MEDIUM = 2'h1;  // 2K program, 96 byte RAM
  localparam logic [1:0] VARIANT_LARGE  = 2'h2;  // 4K program, 160 byte RAM

  // ==========================================================
  // Special-function register offsets
  localparam logic [7:0] ADDR_INDIRECT_WINDOW_0     = 8'h00;
  localparam logic [7:0] ADDR_MEMORY_POINTER_0      = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_WINDOW_1     = 8'h02;
  localparam logic [7:0] ADDR_MEMORY_POINTER_1      = 8'h03;
  localparam logic [7:0] ADDR_ACCUMULATOR           = 8'h05;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW   = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER         = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_BYTE       = 8'h08;
  localparam logic [7:0] ADDR_WATCHDOG_SETUP        = 8'h09;
  localparam logic [7:0] ADDR_STATUS                = 8'h0A;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL_0   = 8'h0B;
  localparam logic [7:0] ADDR_TIMER0_COUNT          = 8'h0D;
  localparam logic [7:0] ADDR_TIMER0_CONTROL        = 8'h0E;
  localparam logic [7:0] ADDR_TIMER1_COUNT          = 8'h10;
  localparam logic [7:0] ADDR_TIMER1_CONTROL        = 8'h11;
  localparam logic [7:0] ADDR_PORT_A_DATA           = 8'h12;
  localparam logic [7:0] ADDR_PORT_A_DIRECTION      = 8'h13;
  localparam logic [7:0] ADDR_PORT_A_PULLUP         = 8'h14;
  localparam logic [7:0] ADDR_PORT_A_WAKEUP         = 8'h15;
  localparam logic [7:0] ADDR_CONTROL_0             = 8'h16;
  localparam logic [7:0] ADDR_CONTROL_1             = 8'h17;
  localparam logic [7:0] ADDR_CONVERSION_RESULT_LOW = 8'h18;
  localparam logic [7:0] ADDR_CONVERSION_RESULT_HIGH= 8'h19;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL     = 8'h1A;
  localparam logic [7:0] ADDR_CONVERTER_CLOCK_SETUP = 8'h1B;
  localparam logic [7:0] ADDR_PULSE_WIDTH_DUTY      = 8'h1C;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL_1   = 8'h1E;

  // ==========================================================
  // General-purpose RAM bounds
  localparam logic [7:0] GPR_START      = 8'h20;
  localparam logic [7:0] GPR_END_SMALL  = 8'h5F;
  localparam logic [7:0] GPR_END_MEDIUM = 8'h7F;
  localparam logic [7:0] GPR_END_LARGE  = 8'hBF;
  localparam int         SFR_COUNT      = 32;

  // ==========================================================
  // Field positions and reset values
  localparam int         POINTER_TOP_BIT  = 7;
  localparam int         STATUS_TO_BIT    = 4;
  localparam int         STATUS_PDF_BIT   = 5;
  localparam logic [7:0] SFR_RESET        = 8'h00;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;

  // ==========================================================
  // Table read address widths and program word masks
  localparam logic [11:0] PROG_MASK_SMALL  = 12'h3FF;  // 10 bits
  localparam logic [11:0] PROG_MASK_MEDIUM = 12'h7FF;  // 11 bits
  localparam logic [11:0] PROG_MASK_LARGE  = 12'hFFF;  // 12 bits
  localparam logic [3:0]  LAST_PAGE_BITS   = 4'hF;
  localparam logic [7:0]  HIGH_MASK_14     = 8'h3F;    // 14-bit words
  localparam logic [7:0]  HIGH_MASK_15     = 8'h7F;    // 15-bit words

  // ==========================================================
  // Table read sequencer
  typedef enum logic [0:0] {
    TAB_IDLE  = 1'b0,
    TAB_FETCH = 1'b1
  } tab_state_t;

endpackage

// File: tb/data_memory_asserts.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the data memory
module data_memory_asserts
  import data_memory_pkg::*;
#(
  parameter logic [1:0] VARIANT = VARIANT_LARGE
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Core access
  input  wire logic [7:0]  addr_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  rd_data_o,
  input  wire logic        wr_en_i,
  input  wire logic [7:0]  wr_data_i,
  // Table read and fetch
  input  wire logic        tab_rd_i,
  input  wire logic        tab_last_i,
  input  wire logic [11:0] pc_i,
  input  wire logic        busy_o,
  input  wire logic        prog_req_o,
  input  wire logic [11:0] prog_addr_o,
  input  wire logic        prog_valid_i,
  // Flags and program counter load
  input  wire logic        status_to_i,
  input  wire logic        status_pdf_i,
  input  wire logic        pcl_wr_o,
  input  wire logic [7:0]  pcl_data_o
);
  localparam logic [11:0] MASK = (VARIANT == VARIANT_SMALL) ? PROG_MASK_SMALL :
                                 (VARIANT == VARIANT_MEDIUM) ? PROG_MASK_MEDIUM : PROG_MASK_LARGE;
  localparam logic [7:0]  RAM_END = (VARIANT == VARIANT_SMALL) ? GPR_END_SMALL :
                                    (VARIANT == VARIANT_MEDIUM) ? GPR_END_MEDIUM : GPR_END_LARGE;
  logic [11:0] pc_q;
  logic [7:0]  wd_q;
  logic [1:0]  flag_q;
  wire logic   hole_w;
  // Holes in the special area, absent registers and space past the RAM
  assign hole_w = (addr_i inside {8'h04, 8'h0C, 8'h0F, 8'h1D, 8'h1F}) || (addr_i > RAM_END) ||
                  (VARIANT == VARIANT_SMALL && addr_i inside {8'h10, 8'h11, 8'h18, 8'h1E});
  // Inputs one cycle back, since answers land a cycle later
  always_ff @(posedge clk_i) begin
    pc_q   <= pc_i;
    wd_q   <= wr_data_i;
    flag_q <= {status_pdf_i, status_to_i};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence tab_go_s;
    tab_rd_i && !busy_o;
  endsequence
  sequence fetch_done_s;
    busy_o && prog_valid_i;
  endsequence
  tab_start_a: assert property (tab_go_s |=> busy_o && prog_req_o)
    else $error("table read did not start a fetch");
  fetch_end_a: assert property (fetch_done_s |=> !busy_o)
    else $error("fetch did not end on valid word");
  fetch_hold_a: assert property (busy_o && !prog_valid_i |=> busy_o)
    else $error("fetch dropped without a word");
  last_page_a: assert property (tab_go_s ##0 tab_last_i |=>
    prog_addr_o[11:8] == (LAST_PAGE_BITS & MASK[11:8]))
    else $error("last page bits not forced");
  cur_page_a: assert property (tab_go_s ##0 !tab_last_i |=>
    prog_addr_o[11:8] == (pc_q[11:8] & MASK[11:8]))
    else $error("current page bits wrong");
  addr_width_a: assert property (busy_o |-> (prog_addr_o & ~MASK) == 12'h000)
    else $error("table address beyond width");
  pcl_pulse_a: assert property (wr_en_i && !busy_o && addr_i == 8'h06 |=>
    pcl_wr_o && pcl_data_o == wd_q)
    else $error("program counter load missing");
  unused_read_a: assert property (rd_en_i && hole_w |=> rd_data_o == ZERO_BYTE)
    else $error("unused location read not zero");
  status_flag_a: assert property (rd_en_i && addr_i == ADDR_STATUS |=>
    rd_data_o[5:4] == flag_q)
    else $error("status flags not live");
  ptr_top_a: assert property (rd_en_i && VARIANT != VARIANT_LARGE &&
    addr_i inside {8'h01, 8'h03} |=> rd_data_o[7])
    else $error("pointer top bit not one");
endmodule

bind data_memory data_memory_asserts #(.VARIANT(VARIANT)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .wr_en_i(wr_en_i),
  .wr_data_i(wr_data_i), .tab_rd_i(tab_rd_i), .tab_last_i(tab_last_i), .pc_i(pc_i),
  .busy_o(busy_o), .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o),
  .prog_valid_i(prog_valid_i), .status_to_i(status_to_i), .status_pdf_i(status_pdf_i),
  .pcl_wr_o(pcl_wr_o), .pcl_data_o(pcl_data_o));

// File: tb/tb.sv
`timescale 1ns/10ps
// ==========================================
// Self-checking bench, small variant
module tb;
  import data_memory_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i, rd_en_i, wr_en_i, bit_en_i, bit_val_i, tab_rd_i, tab_last_i;
  logic        prog_valid_i, status_to_i, status_pdf_i, busy_o, prog_req_o, pcl_wr_o;
  logic [7:0]  addr_i, wr_data_i, tab_dest_i, rd_data_o, pcl_data_o;
  logic [2:0]  bit_sel_i;
  logic [11:0] pc_i, prog_addr_o;
  logic [15:0] prog_data_i;
  int          n_mismatch = 0;
  int          total_checks = 0;
  typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  // Write (optional) then read back; status TO tied high, program counter low BCH
  row_t rows[16] = '{'{1, 8'h20, 8'hA5, 8'hA5}, '{1, 8'h5F, 8'h3C, 8'h3C},
    '{1, 8'h60, 8'h77, 8'h00}, '{1, 8'h05, 8'h5A, 8'h5A}, '{1, 8'h07, 8'h06, 8'h06},
    '{1, 8'h08, 8'hFF, 8'h00}, '{1, 8'h04, 8'hFF, 8'h00}, '{1, 8'h10, 8'h12, 8'h00},
    '{1, 8'h18, 8'h34, 8'h00}, '{1, 8'h1E, 8'h56, 8'h00}, '{1, 8'h19, 8'h81, 8'h81},
    '{1, 8'h01, 8'h21, 8'hA1}, '{1, 8'h00, 8'hC3, 8'hC3}, '{0, 8'h21, 8'h00, 8'hC3},
    '{1, 8'h0A, 8'h00, 8'h10}, '{0, 8'h06, 8'h00, 8'hBC}};

  data_memory #(.VARIANT(VARIANT_SMALL)) uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
    .bit_en_i(bit_en_i), .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i), .tab_rd_i(tab_rd_i),
    .tab_last_i(tab_last_i), .tab_dest_i(tab_dest_i), .pc_i(pc_i), .busy_o(busy_o),
    .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o), .prog_valid_i(prog_valid_i),
    .prog_data_i(prog_data_i), .status_to_i(status_to_i), .status_pdf_i(status_pdf_i),
    .pcl_wr_o(pcl_wr_o), .pcl_data_o(pcl_data_o));

  // ==========================================
  // Clock, tasks and verdict
  always #2 clk_i = ~clk_i;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge, away from sampling
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i = a;
    wr_data_i = d;
    wr_en_i = 1'b1;
    step();
    wr_en_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr_i = a;
    rd_en_i = 1'b1;
    step();
    rd_en_i = 1'b0;
    check(16'(rd_data_o), 16'(e));
  endtask
  task automatic bitop(input logic [7:0] a, input logic [2:0] s, input logic v);
    addr_i = a;
    bit_sel_i = s;
    bit_val_i = v;
    bit_en_i = 1'b1;
    step();
    bit_en_i = 1'b0;
  endtask
  // Fetch answered after n idle busy cycles; data inverted once released
  task automatic tab(input logic l, input logic [7:0] dst, input int n,
                     input logic [15:0] w, input logic [11:0] ea);
    tab_last_i = l;
    tab_dest_i = dst;
    tab_rd_i = 1'b1;
    step();
    tab_rd_i = 1'b0;
    check(16'(busy_o), 16'h0001);
    check(16'(prog_req_o), 16'h0001);
    check(16'(prog_addr_o), 16'(ea));
    repeat (n) step();
    prog_valid_i = 1'b1;
    prog_data_i = w;
    step();
    prog_valid_i = 1'b0;
    prog_data_i = ~w;
    check(16'(busy_o), 16'h0000);
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rst_i, rd_en_i, wr_en_i, bit_en_i, bit_val_i, tab_rd_i, tab_last_i} = 7'h40;
    {prog_valid_i, status_to_i, status_pdf_i, bit_sel_i} = 6'h10;
    {addr_i, wr_data_i, tab_dest_i, pc_i, prog_data_i} = {24'h000000, 12'hABC, 16'h0000};
    repeat (20) step();
    rst_i = 1'b0;
    check(16'(busy_o), 16'h0000);
    rd(8'h05, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Pointer aimed at a window: reads zero, writes lost
    wr(8'h03, 8'h02);
    wr(8'h02, 8'h77);
    rd(8'h02, 8'h00);
    wr(8'h03, 8'h21);
    rd(8'h02, 8'hC3);
    wr(8'h22, 8'h0F);
    bitop(8'h22, 3'h7, 1'b1);
    bitop(8'h22, 3'h0, 1'b0);
    rd(8'h22, 8'h8E);
    tab(1'b1, 8'h23, 0, 16'hFF5A, 12'h306);
    rd(8'h23, 8'h5A);
    rd(8'h08, 8'h3F);
    tab(1'b0, 8'h00, 3, 16'h1234, 12'h206);
    rd(8'h21, 8'h34);
    rd(8'h08, 8'h12);
    wr(8'h06, 8'h44);
    check(16'({pcl_wr_o, pcl_data_o}), 16'h0144);
    rst_i = 1'b1;
    step();
    rst_i = 1'b0;
    rd(8'h01, 8'h80);
    finish_test();
  end
  // Watchdog well beyond the 74 cycles the sequence needs
  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end
endmodule
